// File: rtl/fpsi_top.sv
/*
 * Front-panel indicator driver: turns internal status into lamp states,
 * samples the run/stop switch, and offers a small register port.
 * Assumes status inputs are on core_clk except switch and battery pins.
 */
// Summary of operation
// - The unit-ok lamp is lit steadily once initialization has completed.
// - The unit-ok lamp is dark in reset, on power loss or on a watchdog trip.
// - The program-run lamp is steady on while the program executes.
// - The program-run lamp blinks slowly while halted and editable.
// - The program-run lamp blinks fast while running with waits for port input.
// - The program-run lamp is off when the program is stopped.
// - The error lamp lights on a significant fault and stays lit until cleared through the control register.
// - The battery-low lamp follows the battery-low detector.
// - The write-protect lamp follows the write-protect switch.
// - Each fitted port-activity lamp blinks while its port is busy, dark when idle.
// - Activity lamps of ports absent in the configuration never blink.
// - Eight user lamps are set only by system calls through the register port.
// - The run/stop switch and start setting decide whether the program runs.
`timescale 1ns/1ps
module fpsi_top #(
   parameter fpsi_pkg::fpsi_cfg_t CFG = fpsi_pkg::FPSI_CFG_THREE
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // unit status
   input  wire logic        init_done,
   input  wire logic        power_fail,
   input  wire logic        wdog_trip,
   // program status
   input  wire logic        prog_running,
   input  wire logic        prog_editable,
   input  wire logic        wait_port_input,
   input  wire logic        run_cmd,
   input  wire logic        fault_mem_check,
   input  wire logic        fault_area_ovf,
   input  wire logic        fault_code_gen,
   // pins
   input  wire logic        batt_low_pin,
   input  wire logic        prot_sw_pin,
   input  wire logic        run_sw_pin,
   input  wire logic [2:0]  port_busy,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata_q,
   // lamps
   output logic             unit_ok_lamp,
   output logic             program_run_lamp,
   output logic             error_lamp,
   output logic             battery_low_lamp,
   output logic             write_protect_lamp,
   output logic [2:0]       port_act_lamp,
   output logic [7:0]       user_lamp,
   // program gate and interrupt
   output logic             prog_enable_q,
   output logic             irq_q
);

   // ---------------------------------------------------------------
   // synchronisers
   // ---------------------------------------------------------------
   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   logic       batt_low_s;
   logic       prot_s;
   logic       run_sw_s;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pin_s1_q <= 3'h0;
         pin_s2_q <= 3'h0;
      end else begin
         pin_s1_q <= {run_sw_pin, prot_sw_pin, batt_low_pin};
         pin_s2_q <= pin_s1_q;
      end
   end

   assign batt_low_s = pin_s2_q[0];
   assign prot_s     = pin_s2_q[1];
   assign run_sw_s   = pin_s2_q[2];

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic                      auto_start_q;
   logic                      err_q;
   logic [7:0]                user_q;
   logic [31:0]               slow_div_q;
   logic [31:0]               fast_div_q;
   logic [fpsi_pkg::IRQ_W-1:0] irq_stat_q;
   logic [fpsi_pkg::IRQ_W-1:0] irq_mask_q;
   logic [fpsi_pkg::IRQ_W-1:0] irq_evt;
   logic                      batt_prev_q;
   logic                      run_prev_q;
   logic                      wdog_prev_q;
   logic                      fault_any;
   logic                      div_ok;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   assign fault_any = fault_mem_check | fault_area_ovf | fault_code_gen;
   // reject prescaler pairs where the slow period is less than four times the fast period
   assign div_ok = ({2'b00, reg_wdata} + 34'h1) * 34'(fpsi_pkg::MIN_RATIO)
                   <= ({2'b00, slow_div_q} + 34'h1);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         auto_start_q <= 1'b0;
         user_q       <= fpsi_pkg::USER_RST;
         irq_mask_q   <= fpsi_pkg::MASK_RST;
         slow_div_q   <= 32'(fpsi_pkg::SLOW_HALF_CYC - 1);
         fast_div_q   <= 32'(fpsi_pkg::FAST_HALF_CYC - 1);
      end else if (reg_wr) begin
         if (hit(reg_addr, fpsi_pkg::REG_CTRL)) begin
            auto_start_q <= reg_wdata[fpsi_pkg::CTRL_AUTO];
         end else if (hit(reg_addr, fpsi_pkg::REG_USER)) begin
            user_q <= reg_wdata[7:0];
         end else if (hit(reg_addr, fpsi_pkg::REG_IRQ_MASK)) begin
            irq_mask_q <= reg_wdata[fpsi_pkg::IRQ_W-1:0];
         end else if (hit(reg_addr, fpsi_pkg::REG_SLOW_DIV)) begin
            if (reg_wdata >= 32'h3 && (reg_wdata + 32'h1) >= (fast_div_q + 32'h1) * 32'h4) begin
               slow_div_q <= reg_wdata;
            end
         end else if (hit(reg_addr, fpsi_pkg::REG_FAST_DIV)) begin
            if (div_ok) begin
               fast_div_q <= reg_wdata;
            end
         end
      end
   end

   // error latch: set wins over clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         err_q <= 1'b0;
      end else if (fault_any) begin
         err_q <= 1'b1;
      end else if (reg_wr && hit(reg_addr, fpsi_pkg::REG_CTRL)
                   && reg_wdata[fpsi_pkg::CTRL_ERR_CLR]) begin
         err_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // interrupts
   // ---------------------------------------------------------------
   assign irq_evt[fpsi_pkg::IRQ_ERROR]  = fault_any & ~err_q;
   assign irq_evt[fpsi_pkg::IRQ_BATLOW] = batt_low_s & ~batt_prev_q;
   assign irq_evt[fpsi_pkg::IRQ_SWITCH] = run_sw_s ^ run_prev_q;
   assign irq_evt[fpsi_pkg::IRQ_WDOG]   = wdog_trip & ~wdog_prev_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         batt_prev_q <= 1'b0;
         run_prev_q  <= 1'b0;
         wdog_prev_q <= 1'b0;
         irq_stat_q  <= '0;
         irq_q       <= 1'b0;
      end else begin
         batt_prev_q <= batt_low_s;
         run_prev_q  <= run_sw_s;
         wdog_prev_q <= wdog_trip;
         if (reg_wr && hit(reg_addr, fpsi_pkg::REG_IRQ_STAT)) begin
            irq_stat_q <= (irq_stat_q & ~reg_wdata[fpsi_pkg::IRQ_W-1:0]) | irq_evt;
         end else begin
            irq_stat_q <= irq_stat_q | irq_evt;
         end
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata_q <= 32'h0;
      end else if (reg_rd) begin
         if (hit(reg_addr, fpsi_pkg::REG_CTRL)) begin
            reg_rdata_q <= {31'h0, auto_start_q};
         end else if (hit(reg_addr, fpsi_pkg::REG_USER)) begin
            reg_rdata_q <= {24'h0, user_q};
         end else if (hit(reg_addr, fpsi_pkg::REG_STATUS)) begin
            reg_rdata_q <= {24'h0, run_sw_s, prot_s, batt_low_s, err_q,
                            prog_enable_q, port_busy};
         end else if (hit(reg_addr, fpsi_pkg::REG_IRQ_STAT)) begin
            reg_rdata_q <= {28'h0, irq_stat_q};
         end else if (hit(reg_addr, fpsi_pkg::REG_IRQ_MASK)) begin
            reg_rdata_q <= {28'h0, irq_mask_q};
         end else if (hit(reg_addr, fpsi_pkg::REG_SLOW_DIV)) begin
            reg_rdata_q <= slow_div_q;
         end else if (hit(reg_addr, fpsi_pkg::REG_FAST_DIV)) begin
            reg_rdata_q <= fast_div_q;
         end else begin
            reg_rdata_q <= 32'h0;
         end
      end else begin
         reg_rdata_q <= 32'h0;
      end
   end

   // ---------------------------------------------------------------
   // program gate
   // ---------------------------------------------------------------
   // stop holds the program; run with auto start runs at once,
   // run with manual start waits for a run command
   always_ff @(posedge core_clk) begin
      if (rst || !run_sw_s) begin
         prog_enable_q <= 1'b0;
      end else if (auto_start_q || run_cmd) begin
         prog_enable_q <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // blink sources
   // ---------------------------------------------------------------
   logic slow_ph;
   logic fast_ph;

   fpsi_blink #(.W(32)) u_slow (
      .core_clk (core_clk),
      .rst      (rst),
      .div      (slow_div_q),
      .phase_q  (slow_ph)
   );

   fpsi_blink #(.W(32)) u_fast (
      .core_clk (core_clk),
      .rst      (rst),
      .div      (fast_div_q),
      .phase_q  (fast_ph)
   );

   // ---------------------------------------------------------------
   // program state
   // ---------------------------------------------------------------
   fpsi_pkg::fpsi_state_t st;

   always_comb begin
      if (!init_done) begin
         st = fpsi_pkg::FPSI_ST_INIT;
      end else if (prog_running && prog_enable_q) begin
         st = wait_port_input ? fpsi_pkg::FPSI_ST_WAIT : fpsi_pkg::FPSI_ST_RUN;
      end else if (prog_editable) begin
         st = fpsi_pkg::FPSI_ST_EDIT;
      end else begin
         st = fpsi_pkg::FPSI_ST_STOP;
      end
   end

   // ---------------------------------------------------------------
   // lamps
   // ---------------------------------------------------------------
   localparam logic [2:0] PORT_FIT =
      (CFG == fpsi_pkg::FPSI_CFG_THREE) ? 3'h7 :
      (CFG == fpsi_pkg::FPSI_CFG_TWO)   ? 3'h3 : 3'h1;

   always_ff @(posedge core_clk) begin
      if (rst || power_fail || wdog_trip) begin
         unit_ok_lamp <= 1'b0;
      end else begin
         unit_ok_lamp <= init_done;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         program_run_lamp <= 1'b0;
      end else begin
         case (st)
            fpsi_pkg::FPSI_ST_RUN:  program_run_lamp <= 1'b1;
            fpsi_pkg::FPSI_ST_EDIT: program_run_lamp <= slow_ph;
            fpsi_pkg::FPSI_ST_WAIT: program_run_lamp <= fast_ph;
            default:                program_run_lamp <= 1'b0;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         error_lamp         <= 1'b0;
         battery_low_lamp   <= 1'b0;
         write_protect_lamp <= 1'b0;
         user_lamp          <= fpsi_pkg::USER_RST;
      end else begin
         error_lamp         <= err_q;
         battery_low_lamp   <= batt_low_s;
         write_protect_lamp <= prot_s;
         user_lamp          <= user_q;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_port
         always_ff @(posedge core_clk) begin
            if (rst) begin
               port_act_lamp[gi] <= 1'b0;
            end else begin
               port_act_lamp[gi] <= port_busy[gi] & fast_ph & PORT_FIT[gi];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_unit_dark;
      @(posedge core_clk) (power_fail || wdog_trip) |=> !unit_ok_lamp;
   endproperty
   a_unit_dark: assert property (p_unit_dark) else $error("unit lamp lit in fault");

   property p_unit_on;
      @(posedge core_clk) disable iff (rst)
      (!rst && init_done && !power_fail && !wdog_trip) |=> unit_ok_lamp;
   endproperty
   a_unit_on: assert property (p_unit_on) else $error("unit lamp dark after init");

   property p_run_steady;
      @(posedge core_clk) disable iff (rst)
      (st == fpsi_pkg::FPSI_ST_RUN) |=> program_run_lamp;
   endproperty
   a_run_steady: assert property (p_run_steady) else $error("run lamp not steady");

   property p_stop_off;
      @(posedge core_clk) disable iff (rst)
      (st == fpsi_pkg::FPSI_ST_STOP) |=> !program_run_lamp;
   endproperty
   a_stop_off: assert property (p_stop_off) else $error("run lamp on when stopped");

   property p_edit_slow;
      @(posedge core_clk) disable iff (rst)
      (st == fpsi_pkg::FPSI_ST_EDIT) |=> (program_run_lamp == $past(slow_ph));
   endproperty
   a_edit_slow: assert property (p_edit_slow) else $error("edit blink wrong");

   property p_err_hold;
      @(posedge core_clk) disable iff (rst) fault_any |=> ##1 error_lamp;
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("error lamp missed fault");

   property p_absent_dark;
      @(posedge core_clk) disable iff (rst) (port_act_lamp & ~PORT_FIT) == 3'h0;
   endproperty
   a_absent_dark: assert property (p_absent_dark) else $error("absent port lamp lit");

   sequence s_stop_sw;
      !run_sw_s;
   endsequence
   property p_stop_holds;
      @(posedge core_clk) disable iff (rst) s_stop_sw |=> !prog_enable_q;
   endproperty
   a_stop_holds: assert property (p_stop_holds) else $error("program enabled in stop");

   property p_idle_dark;
      @(posedge core_clk) disable iff (rst) !port_busy[0] |=> !port_act_lamp[0];
   endproperty
   a_idle_dark: assert property (p_idle_dark) else $error("idle port lamp lit");

endmodule

// File: rtl/fpsi_pkg.sv
/*
 * Package for the front-panel indicator driver: port configurations,
 * program states, blink prescaler defaults and the bus register map.
 * Assumes one 100 MHz core clock and a synchronous active-high reset.
 */
package fpsi_pkg;

   // ---------------------------------------------------------------
   // clock
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ        = 100_000_000;

   // ---------------------------------------------------------------
   // blink timing
   // ---------------------------------------------------------------
   localparam int unsigned SLOW_HALF_MS  = 500;
   localparam int unsigned FAST_HALF_MS  = 125;
   localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_MS * (CLK_HZ / 1000);
   localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * (CLK_HZ / 1000);
   localparam int unsigned MIN_RATIO     = 4;

   // ---------------------------------------------------------------
   // register map (byte offsets, 32-bit words)
   // ---------------------------------------------------------------
   localparam logic [7:0]  REG_CTRL      = 8'h00;
   localparam logic [7:0]  REG_USER      = 8'h04;
   localparam logic [7:0]  REG_STATUS    = 8'h08;
   localparam logic [7:0]  REG_IRQ_STAT  = 8'h0C;
   localparam logic [7:0]  REG_IRQ_MASK  = 8'h10;
   localparam logic [7:0]  REG_SLOW_DIV  = 8'h14;
   localparam logic [7:0]  REG_FAST_DIV  = 8'h18;

   // ctrl field positions
   localparam int unsigned CTRL_AUTO     = 0;
   localparam int unsigned CTRL_ERR_CLR  = 1;

   // irq status bits
   localparam int unsigned IRQ_ERROR     = 0;
   localparam int unsigned IRQ_BATLOW    = 1;
   localparam int unsigned IRQ_SWITCH    = 2;
   localparam int unsigned IRQ_WDOG      = 3;
   localparam int unsigned IRQ_W         = 4;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0]  USER_RST      = 8'h00;
   localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      FPSI_CFG_THREE,
      FPSI_CFG_TWO,
      FPSI_CFG_ONE
   } fpsi_cfg_t;

   typedef enum {
      FPSI_ST_INIT,
      FPSI_ST_EDIT,
      FPSI_ST_RUN,
      FPSI_ST_WAIT,
      FPSI_ST_STOP
   } fpsi_state_t;

endpackage

// File: rtl/fpsi_blink.sv
/*
 * Prescaler that toggles a blink phase every DIV+1 clock cycles.
 * Assumes the divisor is stable or that a restart on change is fine.
 */
`timescale 1ns/1ps
module fpsi_blink #(
   parameter int unsigned W = 32
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst,
   // control
   input  wire logic [W-1:0] div,
   // phase
   output logic              phase_q
);

   if (W < 2 || W > 32) begin : g_bad_w
      $error("fpsi_blink: W out of range");
   end

   logic [W-1:0] cnt_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_q   <= '0;
         phase_q <= 1'b0;
      end else if (cnt_q >= div) begin
         cnt_q   <= '0;
         phase_q <= ~phase_q;
      end else begin
         cnt_q   <= cnt_q + 1'b1;
      end
   end

endmodule

// File: test/fpsi_top_tb.sv
/*
 * Self-checking bench for the front-panel indicator driver.
 * Assumes the design package is compiled first; the bench drives every port itself.
 */
`timescale 1ns/1ps
module fpsi_top_tb;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic        core_clk, rst, init_done, power_fail, wdog_trip, run_cmd;
   logic        prog_running, prog_editable, wait_port_input, reg_wr, reg_rd;
   logic        batt_low_pin, prot_sw_pin, run_sw_pin, irq_q, prog_enable_q;
   logic        unit_ok_lamp, program_run_lamp, error_lamp, battery_low_lamp;
   logic        write_protect_lamp;
   logic [2:0]  fault, port_busy, port_act_lamp, b_act;
   logic [7:0]  reg_addr, user_lamp;
   logic [31:0] reg_wdata, reg_rdata_q, d;
   logic [12:0] watch;
   int          num_errors, compares, tog, hi, k;

   // observed bits picked by index in the measuring tasks
   assign watch = {unit_ok_lamp, write_protect_lamp, battery_low_lamp, error_lamp,
                   prog_enable_q, irq_q, b_act, port_act_lamp, program_run_lamp};

   fpsi_top i_dut (
      .core_clk(core_clk), .rst(rst), .init_done(init_done), .power_fail(power_fail),
      .wdog_trip(wdog_trip), .prog_running(prog_running), .prog_editable(prog_editable),
      .wait_port_input(wait_port_input), .run_cmd(run_cmd), .fault_mem_check(fault[0]),
      .fault_area_ovf(fault[1]), .fault_code_gen(fault[2]), .batt_low_pin(batt_low_pin),
      .prot_sw_pin(prot_sw_pin), .run_sw_pin(run_sw_pin), .port_busy(port_busy),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q), .unit_ok_lamp(unit_ok_lamp),
      .program_run_lamp(program_run_lamp), .error_lamp(error_lamp),
      .battery_low_lamp(battery_low_lamp), .write_protect_lamp(write_protect_lamp),
      .port_act_lamp(port_act_lamp), .user_lamp(user_lamp),
      .prog_enable_q(prog_enable_q), .irq_q(irq_q));

   // single-port variant sharing the same inputs
   fpsi_top #(.CFG(fpsi_pkg::FPSI_CFG_ONE)) i_one (
      .core_clk(core_clk), .rst(rst), .init_done(init_done), .power_fail(power_fail),
      .wdog_trip(wdog_trip), .prog_running(prog_running), .prog_editable(prog_editable),
      .wait_port_input(wait_port_input), .run_cmd(run_cmd), .fault_mem_check(fault[0]),
      .fault_area_ovf(fault[1]), .fault_code_gen(fault[2]), .batt_low_pin(batt_low_pin),
      .prot_sw_pin(prot_sw_pin), .run_sw_pin(run_sw_pin), .port_busy(port_busy),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_q(), .unit_ok_lamp(), .program_run_lamp(), .error_lamp(),
      .battery_low_lamp(), .write_protect_lamp(), .port_act_lamp(b_act),
      .user_lamp(), .prog_enable_q(), .irq_q());

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata_q;
   endtask

   // bounded wait for one observed bit; a miss ends the run
   task automatic wait_bit(input int sel, input logic val);
      int i;
      #1;
      for (i = 0; i < 40 && watch[sel] !== val; i++) begin
         @(posedge core_clk);
         #1;
      end
      check(32'(watch[sel]), 32'(val));
      if (watch[sel] !== val) begin
         summarize();
      end
   endtask

   // counts toggles and lit cycles of one observed bit over 64 cycles
   task automatic measure(input int sel);
      logic last;
      @(posedge core_clk);
      #1;
      last = watch[sel];
      tog  = 0;
      hi   = 0;
      repeat (64) begin
         @(posedge core_clk);
         #1;
         if (watch[sel] !== last) begin
            tog++;
         end
         last = watch[sel];
         hi   = hi + (watch[sel] === 1'b1);
      end
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {init_done, power_fail, wdog_trip, prog_running, prog_editable, wait_port_input,
       run_cmd, batt_low_pin, prot_sw_pin, run_sw_pin, reg_wr, reg_rd} = '0;
      fault      = '0;
      port_busy  = '0;
      reg_addr   = '0;
      reg_wdata  = '0;
      rst        = 1'b1;
      num_errors = 0;
      compares   = 0;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      #1 check(32'(unit_ok_lamp), 32'h0);
      @(posedge core_clk);
      init_done <= 1'b1;
      wait_bit(12, 1'b1);
      $display("test reset done");

      reg_write(fpsi_pkg::REG_FAST_DIV, 32'h1);
      reg_write(fpsi_pkg::REG_SLOW_DIV, 32'hF);
      reg_write(fpsi_pkg::REG_SLOW_DIV, 32'h2);
      reg_write(fpsi_pkg::REG_FAST_DIV, 32'h4);
      reg_read(fpsi_pkg::REG_SLOW_DIV);
      check(d, 32'hF);
      reg_read(fpsi_pkg::REG_FAST_DIV);
      check(d, 32'h1);
      $display("test divisors done");

      reg_write(fpsi_pkg::REG_CTRL, 32'h0);
      @(posedge core_clk);
      run_sw_pin <= 1'b1;
      repeat (10) @(posedge core_clk);
      #1 check(32'(prog_enable_q), 32'h0);
      @(posedge core_clk);
      run_cmd <= 1'b1;
      @(posedge core_clk);
      run_cmd <= 1'b0;
      wait_bit(8, 1'b1);
      @(posedge core_clk);
      run_sw_pin   <= 1'b0;
      prog_running <= 1'b1;
      wait_bit(8, 1'b0);
      measure(0);
      check(32'(hi), 32'h0);
      reg_write(fpsi_pkg::REG_CTRL, 32'h1 << fpsi_pkg::CTRL_AUTO);
      @(posedge core_clk);
      run_sw_pin <= 1'b1;
      wait_bit(8, 1'b1);
      measure(0);
      check(32'(hi), 32'h40);
      @(posedge core_clk);
      wait_port_input <= 1'b1;
      measure(0);
      check(32'(tog >= 28 && tog <= 33), 32'h1);
      @(posedge core_clk);
      {prog_running, wait_port_input, prog_editable} <= 3'b001;
      measure(0);
      check(32'(tog >= 3 && tog <= 5), 32'h1);
      @(posedge core_clk);
      prog_editable <= 1'b0;
      $display("test program lamp done");

      @(posedge core_clk);
      port_busy <= 3'h7;
      for (k = 1; k < 7; k++) begin
         measure(k);
         check(32'(tog >= 28), 32'(k <= 4));
      end
      @(posedge core_clk);
      port_busy <= 3'h0;
      for (k = 1; k < 4; k++) begin
         measure(k);
         check(32'(hi), 32'h0);
      end
      $display("test port lamps done");

      for (k = 10; k < 12; k++) begin
         @(posedge core_clk);
         {prot_sw_pin, batt_low_pin} <= 2'(k - 9);
         wait_bit(k, 1'b1);
         @(posedge core_clk);
         {prot_sw_pin, batt_low_pin} <= 2'b00;
         wait_bit(k, 1'b0);
      end
      $display("test pin lamps done");

      reg_read(fpsi_pkg::REG_IRQ_STAT);
      check(d, 32'h6);
      reg_write(fpsi_pkg::REG_IRQ_STAT, 32'hF);
      reg_write(fpsi_pkg::REG_IRQ_MASK, 32'h1 << fpsi_pkg::IRQ_ERROR);
      for (k = 0; k < 4; k++) begin
         if (k == 3) begin
            reg_write(fpsi_pkg::REG_IRQ_MASK, 32'h0);
         end
         @(posedge core_clk);
         fault <= 3'(1 << (k % 3));
         @(posedge core_clk);
         fault <= 3'h0;
         wait_bit(9, 1'b1);
         wait_bit(7, (k < 3));
         reg_read(fpsi_pkg::REG_IRQ_STAT);
         check(32'(d[fpsi_pkg::IRQ_ERROR]), 32'h1);
         reg_write(fpsi_pkg::REG_IRQ_STAT, 32'h1 << fpsi_pkg::IRQ_ERROR);
         reg_write(fpsi_pkg::REG_CTRL, 32'h3);
         wait_bit(7, 1'b0);
         wait_bit(9, 1'b0);
      end
      $display("test error lamp done");

      reg_write(fpsi_pkg::REG_USER, 32'hA5);
      @(posedge core_clk);
      #1 check(32'(user_lamp), 32'hA5);
      reg_write(fpsi_pkg::REG_USER, 32'h5A);
      reg_write(8'h1C, 32'hFF);
      reg_read(fpsi_pkg::REG_USER);
      check(d, 32'h5A);
      check(32'(user_lamp), 32'h5A);
      reg_read(8'h1C);
      check(d, 32'h0);
      reg_read(fpsi_pkg::REG_STATUS);
      check(d, 32'h88);
      $display("test user lamps done");

      @(posedge core_clk);
      power_fail <= 1'b1;
      wait_bit(12, 1'b0);
      @(posedge core_clk);
      power_fail <= 1'b0;
      rst        <= 1'b1;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      #1 check(32'(unit_ok_lamp), 32'h0);
      wait_bit(12, 1'b1);
      @(posedge core_clk);
      wdog_trip <= 1'b1;
      wait_bit(12, 1'b0);
      $display("test unit lamp done");
      summarize();
   end
endmodule
